// File: rtl/mgaf_pkg.sv
// Constants and types shared by the pin block with alternate functions.
// Assumes a 20 MHz bus clock and one AHB-Lite master on the register bus.
//
// Behaviour
// [RL1] Each pad is input, output or alternate.
// [RL2] Input pads read the live pad level.
// [RL3] Output pads drive and report written level.
// [RL4] Alternate pads follow only their internal function.
// [RL5] Reset: all pads input, held low; the code holds the alarm pad high.
// [RL6] Alternates only on pads one, four to seven.
// [RL7] Output pads drive push-pull, both levels.
// [RL8] Pad four low inhibits the transmitter.
// [RL9] Pad five high while transmit activity lasts.
// [RL10] Monitor leads burst 300 ms, lags 500 ms-1 s.
// [RL11] Alarm pad rises, holds until clear command.
// [RL12] Alarm pad held high during reset.
// [RL13] Pad seven alternate forces output; buzzer needs select.
// [RL14] Host sets alternate, waits, then sends select.
// [RL15] Buzzer pad reports dummy level as high.
// [RL16] Alternate requests on unsupported pads are rejected.

package mgaf_pkg;

	// Pad population; pad n sits at index n-1.
	localparam int MGAF_NPADS = 9;
	localparam logic [8:0] MGAF_ALT_PADS = 9'h079;
	localparam logic [8:0] MGAF_ALT_OE = 9'h071;

	// Pad modes as stored in the mode register, two bits per pad.
	typedef enum logic [1:0] {
		MGAF_MODE_IN = 2'b00,
		MGAF_MODE_OUT = 2'b01,
		MGAF_MODE_ALT = 2'b10
	} mgaf_mode_t;

	// Register byte offsets.
	localparam logic [7:0] MGAF_OFF_MODE = 8'h00;
	localparam logic [7:0] MGAF_OFF_LEVEL = 8'h04;
	localparam logic [7:0] MGAF_OFF_PADS = 8'h08;
	localparam logic [7:0] MGAF_OFF_CMD = 8'h0C;

	// Command codes written to the command register.
	localparam logic [1:0] MGAF_CMD_ALARM_CLR = 2'h1;
	localparam logic [1:0] MGAF_CMD_BUZZ_SEL = 2'h3;

	// Pad values while reset is asserted: all driven, only the alarm pad high.
	localparam logic [8:0] MGAF_PAD_RST_OUT = 9'h020;
	localparam logic [8:0] MGAF_PAD_RST_OE = 9'h1FF;

	// Transmit monitor timing.
	localparam int MGAF_CLK_HZ = 20000000;
	localparam int MGAF_TX_LEAD_MS = 300;
	localparam int MGAF_TX_LAG_MS = 500;
	localparam int MGAF_CYC_PER_MS = (MGAF_CLK_HZ + 999) / 1000;
	localparam int MGAF_TX_LEAD_CYC = MGAF_TX_LEAD_MS * MGAF_CYC_PER_MS;
	localparam int MGAF_TX_LAG_CYC = MGAF_TX_LAG_MS * MGAF_CYC_PER_MS;
	localparam int MGAF_CNT_W = 24;

	// Pad drive bundle.
	typedef struct packed {
		logic [MGAF_NPADS-1:0] out;
		logic [MGAF_NPADS-1:0] oe;
	} mgaf_pads_t;

	// Top-level state: pad setup, pad drive and bus slave.
	typedef struct packed {
		logic [MGAF_NPADS-1:0][1:0] mode;
		logic [MGAF_NPADS-1:0] level;
		logic [MGAF_NPADS-1:0] pad_out;
		logic [MGAF_NPADS-1:0] pad_oe;
		logic tx_inhibit;
		logic [7:0] addr;
		logic wr_pend;
		logic rd_pend;
		logic ready;
		logic resp;
		logic [31:0] rdata;
	} mgaf_top_state_t;

	localparam mgaf_top_state_t MGAF_TOP_RST = '{
		mode: '0, level: '0, pad_out: MGAF_PAD_RST_OUT, pad_oe: MGAF_PAD_RST_OE,
		tx_inhibit: 1'b0, addr: 8'h00, wr_pend: 1'b0, rd_pend: 1'b0,
		ready: 1'b1, resp: 1'b0, rdata: 32'h0000_0000
	};

	// Transmit monitor sequencer.
	typedef enum logic [1:0] {
		MGAF_TX_IDLE = 2'b00,
		MGAF_TX_LEAD = 2'b01,
		MGAF_TX_BURST = 2'b10,
		MGAF_TX_LAG = 2'b11
	} mgaf_tx_state_t;

	typedef struct packed {
		mgaf_tx_state_t st;
		logic [MGAF_CNT_W-1:0] cnt;
		logic mon;
		logic ok;
	} mgaf_tx_reg_t;

	// Alarm and buzzer latches.
	typedef struct packed {
		logic alarm_on;
		logic buzz_on;
	} mgaf_fn_reg_t;

endpackage

// File: rtl/mgaf_funcs.sv
// Alarm latch and buzzer enable for the pin block.
// Assumes single-cycle command pulses from the register slave.

`timescale 1ns/100ps

module mgaf_funcs
	import mgaf_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Events and commands.
	input wire logic alarm_event,
	input wire logic alarm_clear,
	input wire logic buzz_select,
	input wire logic buzz_allowed,
	// Function levels.
	output logic alarm_on,
	output logic buzz_on
);

	mgaf_fn_reg_t state_reg;
	mgaf_fn_reg_t state_next;

	// The alarm event beats a clear in the same cycle, so no alarm is lost.
	always_comb begin
		state_next = state_reg;
		state_next.alarm_on = alarm_event | (state_reg.alarm_on & ~alarm_clear); // RL11
		state_next.buzz_on = buzz_allowed & (state_reg.buzz_on | buzz_select); // RL13
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign alarm_on = state_reg.alarm_on;
	assign buzz_on = state_reg.buzz_on;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_clear_only;
		alarm_clear && !alarm_event;
	endsequence

	property p_alarm_hold;
		alarm_on && !alarm_clear |=> alarm_on;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped without clear"); // RL11

	property p_alarm_clear;
		s_clear_only |=> !alarm_on;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm survived clear"); // RL11

	property p_buzz_arm;
		$rose(buzz_on) |-> $past(buzz_select) && $past(buzz_allowed);
	endproperty
	a_buzz_arm: assert property (p_buzz_arm) else $error("buzzer on without select"); // RL13

endmodule

// File: rtl/mgaf_txmon.sv
// Transmit activity monitor sequencer.
// Assumes the radio firmware holds tx_request high while it wants to send.

`timescale 1ns/100ps

module mgaf_txmon
	import mgaf_pkg::*;
#(
	parameter int LEAD_CYCLES = MGAF_TX_LEAD_CYC,
	parameter int LAG_CYCLES = MGAF_TX_LAG_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Firmware side.
	input wire logic tx_request,
	output logic burst_ok,
	// Monitor line level.
	output logic mon
);

	// Bursts wait one count beyond the lead, because the pad follows the
	// monitor level through one more register stage in the top.
	localparam logic [MGAF_CNT_W-1:0] LEAD_LAST = MGAF_CNT_W'(LEAD_CYCLES);
	localparam logic [MGAF_CNT_W-1:0] LAG_LAST = MGAF_CNT_W'(LAG_CYCLES - 1);

	mgaf_tx_reg_t state_reg;
	mgaf_tx_reg_t state_next;

	// The line rises at once and bursts wait out the lead; a new request
	// during the lag resumes bursting because the line never fell.
	always_comb begin
		state_next = state_reg;
		state_next.cnt = state_reg.cnt + 1'b1;
		unique case (state_reg.st)
			MGAF_TX_IDLE: begin
				state_next.cnt = '0;
				if (tx_request) begin
					state_next.st = MGAF_TX_LEAD;
					state_next.mon = 1'b1; // RL9
				end
			end
			MGAF_TX_LEAD: begin
				if (!tx_request) begin
					state_next.st = MGAF_TX_LAG;
					state_next.cnt = '0;
				end else if (state_reg.cnt == LEAD_LAST) begin
					state_next.st = MGAF_TX_BURST; // RL10
					state_next.ok = 1'b1;
				end
			end
			MGAF_TX_BURST: begin
				state_next.cnt = '0;
				if (!tx_request) begin
					state_next.st = MGAF_TX_LAG;
					state_next.ok = 1'b0;
				end
			end
			MGAF_TX_LAG: begin
				if (tx_request) begin
					state_next.st = MGAF_TX_BURST;
					state_next.ok = 1'b1;
				end else if (state_reg.cnt == LAG_LAST) begin
					state_next.st = MGAF_TX_IDLE; // RL10
					state_next.mon = 1'b0; // RL9
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '{st: MGAF_TX_IDLE, cnt: '0, mon: 1'b0, ok: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign burst_ok = state_reg.ok;
	assign mon = state_reg.mon;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_lead_time;
		$rose(burst_ok) && ($past(state_reg.st) == MGAF_TX_LEAD) |-> $past(state_reg.cnt) == LEAD_LAST;
	endproperty
	a_lead_time: assert property (p_lead_time) else $error("burst before lead time"); // RL10

	property p_lag_time;
		$fell(mon) |-> $past(state_reg.cnt) == LAG_LAST && !$past(tx_request);
	endproperty
	a_lag_time: assert property (p_lag_time) else $error("monitor fell early"); // RL10

	property p_ok_under_mon;
		burst_ok |-> mon;
	endproperty
	a_ok_under_mon: assert property (p_ok_under_mon) else $error("burst with monitor low"); // RL9

endmodule

// File: rtl/mgaf_top.sv
// Pin block with plain input, plain output and alternate functions,
// reached over an AHB-Lite slave with four word registers.
// Assumes a single master, word transfers only, and pad inputs that are
// synchronous to hclk; the bench resolves pad wires from the enables.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.

`timescale 1ns/100ps

module mgaf_top
	import mgaf_pkg::*;
#(
	parameter int LEAD_CYCLES = MGAF_TX_LEAD_CYC,
	parameter int LAG_CYCLES = MGAF_TX_LAG_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Pads.
	input wire logic [MGAF_NPADS-1:0] pad_in,
	output mgaf_pads_t pads,
	// Internal firmware functions.
	input wire logic jamming_detect_output,
	input wire logic tx_request,
	input wire logic alarm_event,
	input wire logic buzzer_wave,
	output logic tx_inhibit,
	output logic tx_burst_ok
);

	mgaf_top_state_t state_reg;
	mgaf_top_state_t state_next;

	logic take;
	logic cmd_wr;
	logic alarm_clr;
	logic buzz_sel;
	logic buzz_allowed;
	logic alarm_on;
	logic buzz_on;
	logic tx_mon;
	logic [MGAF_NPADS-1:0] in_mask;
	logic [MGAF_NPADS-1:0] out_mask;
	logic [MGAF_NPADS-1:0] alt_mask;
	logic [MGAF_NPADS-1:0] alt_lvl;
	logic [MGAF_NPADS-1:0] alt_view;
	logic [MGAF_NPADS-1:0] in_view;
	logic [31:0] rd_value;

	// Marks the pads whose stored mode equals the given code.
	function automatic logic [MGAF_NPADS-1:0] mode_mask(
		input logic [MGAF_NPADS-1:0][1:0] m,
		input mgaf_mode_t code
	);
		logic [MGAF_NPADS-1:0] r;
		r = '0;
		for (int i = 0; i < MGAF_NPADS; i++) begin
			r[i] = (m[i] == code);
		end
		return r;
	endfunction

	// A mode value is kept only if the pad can take it; code 3 is never kept.
	function automatic logic mode_ok(input logic [1:0] v, input logic sup);
		return (v == MGAF_MODE_IN) | (v == MGAF_MODE_OUT) | ((v == MGAF_MODE_ALT) & sup);
	endfunction

	// Mode decode of the current setup.
	assign in_mask = mode_mask(state_reg.mode, MGAF_MODE_IN);
	assign out_mask = mode_mask(state_reg.mode, MGAF_MODE_OUT);
	assign alt_mask = mode_mask(state_reg.mode, MGAF_MODE_ALT);

	// Levels the internal functions put on their pads.
	always_comb begin
		alt_lvl = '0;
		alt_lvl[0] = jamming_detect_output; // RL6
		alt_lvl[3] = pad_in[3];
		alt_lvl[4] = tx_mon; // RL9
		alt_lvl[5] = alarm_on; // RL11
		alt_lvl[6] = buzz_on & buzzer_wave; // RL13
	end

	// The buzzer pad reports a dummy high once armed, not the tone itself.
	always_comb begin
		alt_view = alt_lvl;
		alt_view[6] = buzz_on; // RL15
	end

	// What a read of the pad register shows for each pad.
	assign in_view = (in_mask & pad_in) | (out_mask & state_reg.level) | (alt_mask & alt_view); // RL2 RL3

	// Bus address phase acceptance and command decode in the write data phase.
	assign take = hsel & hready & htrans[1];
	assign cmd_wr = state_reg.wr_pend & (state_reg.addr == MGAF_OFF_CMD);
	assign alarm_clr = cmd_wr & (hwdata[1:0] == MGAF_CMD_ALARM_CLR);
	assign buzz_sel = cmd_wr & (hwdata[1:0] == MGAF_CMD_BUZZ_SEL); // RL14
	assign buzz_allowed = alt_mask[6];

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rd_value = 32'h0000_0000;
		case (state_reg.addr)
			MGAF_OFF_MODE: rd_value = 32'(state_reg.mode);
			MGAF_OFF_LEVEL: rd_value = 32'(state_reg.level);
			MGAF_OFF_PADS: rd_value = 32'(in_view);
			MGAF_OFF_CMD: begin
				rd_value = 32'({tx_burst_ok, tx_mon, state_reg.tx_inhibit, buzz_on, alarm_on});
			end
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// Next state: register writes, bus handshake and pad drive.
	// Reads take one wait state so that the data is sampled after any
	// write in the preceding data phase has landed.
	always_comb begin
		state_next = state_reg;
		state_next.resp = 1'b0;
		if (state_reg.wr_pend && (state_reg.addr == MGAF_OFF_MODE)) begin
			for (int i = 0; i < MGAF_NPADS; i++) begin
				if (mode_ok(hwdata[2*i +: 2], MGAF_ALT_PADS[i])) begin // RL16
					state_next.mode[i] = hwdata[2*i +: 2]; // RL1
				end
			end
		end
		if (state_reg.wr_pend && (state_reg.addr == MGAF_OFF_LEVEL)) begin
			state_next.level = hwdata[MGAF_NPADS-1:0]; // RL3
		end
		state_next.wr_pend = take & hwrite;
		state_next.rd_pend = take & ~hwrite;
		if (take) begin
			state_next.addr = haddr[7:0];
		end
		state_next.ready = ~(take & ~hwrite);
		if (state_reg.rd_pend) begin
			state_next.rdata = rd_value;
		end
		for (int i = 0; i < MGAF_NPADS; i++) begin
			if (out_mask[i]) begin
				state_next.pad_oe[i] = 1'b1; // RL7
				state_next.pad_out[i] = state_reg.level[i]; // RL3
			end else if (alt_mask[i]) begin
				state_next.pad_oe[i] = MGAF_ALT_OE[i]; // RL4 RL13
				state_next.pad_out[i] = alt_lvl[i] & MGAF_ALT_OE[i]; // RL4
			end else begin
				state_next.pad_oe[i] = 1'b0; // RL2
				state_next.pad_out[i] = 1'b0;
			end
		end
		state_next.tx_inhibit = alt_mask[3] & ~pad_in[3]; // RL8
	end

	// State register; reset drives every pad low except the alarm pad.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= MGAF_TOP_RST; // RL5 RL12
		end else begin
			state_reg <= state_next;
		end
	end

	// Alarm latch and buzzer enable.
	mgaf_funcs u_funcs (
		.hclk(hclk),
		.hresetn(hresetn),
		.alarm_event(alarm_event),
		.alarm_clear(alarm_clr),
		.buzz_select(buzz_sel),
		.buzz_allowed(buzz_allowed),
		.alarm_on(alarm_on),
		.buzz_on(buzz_on)
	);

	// Transmit monitor; runs whatever the pad mode, so the status bit is
	// valid even when pad five is used as plain I/O.
	mgaf_txmon #(
		.LEAD_CYCLES(LEAD_CYCLES),
		.LAG_CYCLES(LAG_CYCLES)
	) u_txmon (
		.hclk(hclk),
		.hresetn(hresetn),
		.tx_request(tx_request),
		.burst_ok(tx_burst_ok),
		.mon(tx_mon)
	);

	// Outputs straight from the state register.
	assign hreadyout = state_reg.ready;
	assign hresp = state_reg.resp;
	assign hrdata = state_reg.rdata;
	assign pads = '{out: state_reg.pad_out, oe: state_reg.pad_oe};
	assign tx_inhibit = state_reg.tx_inhibit;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_read_take;
		take && !hwrite;
	endsequence

	sequence s_read_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_read_wait;
		s_read_take |=> s_read_answer;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

	property p_in_no_drive;
		$past(hresetn) |-> (pads.oe & $past(in_mask)) == 9'h000;
	endproperty
	a_in_no_drive: assert property (p_in_no_drive) else $error("input pad driven"); // RL2

	property p_in_read;
		state_reg.rd_pend && (state_reg.addr == MGAF_OFF_PADS) && in_mask[1]
			|=> hrdata[1] == $past(pad_in[1]);
	endproperty
	a_in_read: assert property (p_in_read) else $error("input read wrong"); // RL2

	property p_out_level;
		(pads.out & $past(out_mask)) == ($past(state_reg.level) & $past(out_mask));
	endproperty
	a_out_level: assert property (p_out_level) else $error("output level wrong"); // RL3

	property p_out_push_pull;
		(pads.oe & $past(out_mask)) == $past(out_mask);
	endproperty
	a_out_push_pull: assert property (p_out_push_pull) else $error("output not driven"); // RL7

	property p_alt_legal;
		(alt_mask & ~MGAF_ALT_PADS) == 9'h000;
	endproperty
	a_alt_legal: assert property (p_alt_legal) else $error("alternate on bad pad"); // RL16

	property p_jam_pin;
		alt_mask[0] |=> pads.out[0] == $past(jamming_detect_output) && pads.oe[0];
	endproperty
	a_jam_pin: assert property (p_jam_pin) else $error("jamming pad wrong"); // RL6

	property p_tx_inhibit;
		alt_mask[3] && !pad_in[3] |=> tx_inhibit;
	endproperty
	a_tx_inhibit: assert property (p_tx_inhibit) else $error("transmitter not inhibited"); // RL8

	property p_mon_pin;
		alt_mask[4] |=> pads.out[4] == $past(tx_mon) && pads.oe[4];
	endproperty
	a_mon_pin: assert property (p_mon_pin) else $error("monitor pad wrong"); // RL9

	property p_alarm_pin;
		alt_mask[5] |=> pads.out[5] == $past(alarm_on);
	endproperty
	a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pad not function"); // RL4

	property p_buzz_dir;
		alt_mask[6] |=> pads.oe[6];
	endproperty
	a_buzz_dir: assert property (p_buzz_dir) else $error("buzzer pad not output"); // RL13

	property p_buzz_dummy;
		alt_mask[6] && buzz_on |-> in_view[6];
	endproperty
	a_buzz_dummy: assert property (p_buzz_dummy) else $error("buzzer dummy not high"); // RL15

	// Mode writes and refusals; pad one takes every legal code, pad two never
	// takes the alternate code, so a refused field must leave it unchanged.
	property p_mode_write;
		state_reg.wr_pend && (state_reg.addr == MGAF_OFF_MODE) && (hwdata[1:0] != 2'h3)
			|=> state_reg.mode[0] == $past(hwdata[1:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("pad one mode lost"); // RL1

	property p_alt_refused;
		state_reg.wr_pend && (state_reg.addr == MGAF_OFF_MODE) && (hwdata[3:2] == MGAF_MODE_ALT)
			|=> state_reg.mode[1] == $past(state_reg.mode[1]);
	endproperty
	a_alt_refused: assert property (p_alt_refused) else $error("pad two took alternate"); // RL16

	property p_tx_release;
		!(alt_mask[3] && !pad_in[3]) |=> !tx_inhibit;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("transmitter inhibited wrongly"); // RL8

	property p_buzz_idle;
		alt_mask[6] && !buzz_on |=> !pads.out[6];
	endproperty
	a_buzz_idle: assert property (p_buzz_idle) else $error("buzzer driven before select"); // RL13

	property p_alarm_dir;
		alt_mask[5] |=> pads.oe[5];
	endproperty
	a_alarm_dir: assert property (p_alarm_dir) else $error("alarm pad not driven"); // RL11

	// Writes never stall the bus.
	property p_write_ready;
		take && hwrite |=> hreadyout;
	endproperty
	a_write_ready: assert property (p_write_ready) else $error("write wait state inserted");

endmodule

// File: dv/mgaf_pad_host.sv
// Far-side model: the host logic that drives or reads each pad.
// Assumes the block drives a pad only while its enable for that pad is high.

`timescale 1ns/100ps

module mgaf_pad_host
	import mgaf_pkg::*;
(
	// Clock.
	input wire logic hclk,
	// Block drive and host drive request.
	input wire mgaf_pads_t pads,
	input wire logic [MGAF_NPADS-1:0] ext_lvl,
	input wire logic [MGAF_NPADS-1:0] ext_en,
	// Resolved pad level seen by the block.
	output logic [MGAF_NPADS-1:0] pad_in
);
	logic [MGAF_NPADS-1:0] float_reg = 9'h0AA;

	// A floating pad wanders, so an undriven line never looks like a steady level.
	always_ff @(posedge hclk) begin
		float_reg <= ~float_reg;
	end

	// Block drive wins; pad four carries its external pull-up.
	always_comb begin
		for (int i = 0; i < MGAF_NPADS; i++) begin
			if (pads.oe[i]) begin
				pad_in[i] = pads.out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_lvl[i];
			end else if (i == 3) begin
				pad_in[i] = 1'b1;
			end else begin
				pad_in[i] = float_reg[i];
			end
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the pin block with alternate functions.
// Assumes short monitor counts (lead 8, lag 12) and a single bus master.

`timescale 1ns/100ps

module tb;
	import mgaf_pkg::*;
	localparam int LEAD = 8;
	localparam int LAG = 12;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	mgaf_pads_t pads;
	logic [MGAF_NPADS-1:0] pad_in, ext_lvl, ext_en;
	logic jam, tx_request, alarm_event, buzzer_wave, tx_inhibit, tx_burst_ok;
	int n_mismatch = 0;
	int samples_checked = 0;

	assign hready = hreadyout;

	mgaf_top #(.LEAD_CYCLES(LEAD), .LAG_CYCLES(LAG)) i_mgaf_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
		.pads(pads), .jamming_detect_output(jam), .tx_request(tx_request),
		.alarm_event(alarm_event), .buzzer_wave(buzzer_wave), .tx_inhibit(tx_inhibit),
		.tx_burst_ok(tx_burst_ok));

	mgaf_pad_host i_mgaf_pad_host (.hclk(hclk), .pads(pads), .ext_lvl(ext_lvl),
		.ext_en(ext_en), .pad_in(pad_in));

	// Clock at 20 MHz.
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic end_sim();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One word transfer; the master holds each phase until hready is sampled high.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0, "response not okay");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		ahb(1'b1, a, wd, unused);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	// Reset drive levels, then every pad an undriven input.
	task automatic t_reset();
		#1;
		chk({23'h0, pads.oe}, 32'h1FF, "reset enables");
		chk({23'h0, pads.out}, 32'h020, "reset levels");
		@(posedge hclk);
		hresetn <= 1'b1;
		settle(1);
		chk({23'h0, pads.oe}, 32'h0, "inputs after reset");
		@(posedge hclk);
		ahb(1'b0, MGAF_OFF_MODE, 32'h0, rd);
		chk(rd, 32'h0, "mode after reset");
	endtask

	// Input pads report the host level at the read.
	task automatic t_input();
		ext_en <= 9'h1FF;
		ext_lvl <= 9'h0A5;
		@(posedge hclk);
		ahb(1'b0, MGAF_OFF_PADS, 32'h0, rd);
		chk(rd, 32'h0A5, "input read");
		ext_lvl <= 9'h15A;
		@(posedge hclk);
		ahb(1'b0, MGAF_OFF_PADS, 32'h0, rd);
		chk(rd, 32'h15A, "input read two");
		ext_en <= 9'h000;
	endtask

	// Output pads drive both levels and report the written level.
	task automatic t_output();
		wr(MGAF_OFF_MODE, 32'h0001_5555);
		wr(MGAF_OFF_LEVEL, 32'h0000_0155);
		settle(2);
		chk({23'h0, pads.oe}, 32'h1FF, "output enables");
		chk({23'h0, pads.out}, 32'h155, "output levels");
		ahb(1'b0, MGAF_OFF_PADS, 32'h0, rd);
		chk(rd, 32'h155, "output query");
	endtask

	// Alternate requested everywhere; early buzzer select must be ignored.
	task automatic t_alt_sel();
		wr(MGAF_OFF_MODE, 32'h0);
		wr(MGAF_OFF_CMD, {30'h0, MGAF_CMD_BUZZ_SEL});
		wr(MGAF_OFF_MODE, 32'h0002_AAAA);
		ahb(1'b0, MGAF_OFF_MODE, 32'h0, rd);
		chk(rd, 32'h0000_2A82, "alternate only on capable pads");
		settle(1);
		chk({23'h0, pads.oe}, {23'h0, MGAF_ALT_OE}, "alternate enables");
		chk({31'h0, pads.out[6]}, 32'h0, "buzzer idle before select");
		ahb(1'b0, MGAF_OFF_CMD, 32'h0, rd);
		chk(rd, 32'h0, "buzzer not armed early");
	endtask

	// Jamming, pad-four inhibit, alarm and buzzer functions each own their pad.
	task automatic t_alt_fn();
		jam <= 1'b1;
		ext_en <= 9'h008;
		ext_lvl <= 9'h000;
		wr(MGAF_OFF_LEVEL, 32'h0);
		settle(2);
		chk({31'h0, pads.out[0]}, 32'h1, "jamming pad");
		chk({31'h0, tx_inhibit}, 32'h1, "pad four low inhibits");
		ext_lvl <= 9'h008;
		alarm_event <= 1'b1;
		@(posedge hclk);
		alarm_event <= 1'b0;
		settle(2);
		chk({31'h0, tx_inhibit}, 32'h0, "pad four high releases");
		chk({31'h0, pads.out[5]}, 32'h1, "alarm raised");
		settle(3);
		chk({31'h0, pads.out[5]}, 32'h1, "alarm held");
		@(posedge hclk);
		wr(MGAF_OFF_CMD, {30'h0, MGAF_CMD_ALARM_CLR});
		settle(1);
		chk({31'h0, pads.out[5]}, 32'h0, "alarm cleared");
		@(posedge hclk);
		wr(MGAF_OFF_CMD, {30'h0, MGAF_CMD_BUZZ_SEL});
		buzzer_wave <= 1'b1;
		settle(2);
		chk({31'h0, pads.out[6]}, 32'h1, "buzzer follows tone");
		buzzer_wave <= 1'b0;
		wr(MGAF_OFF_LEVEL, 32'h0000_0040);
		settle(2);
		chk({31'h0, pads.out[6]}, 32'h0, "buzzer ignores level");
		ahb(1'b0, MGAF_OFF_PADS, 32'h0, rd);
		chk({31'h0, rd[6]}, 32'h1, "buzzer dummy status");
	endtask

	// Monitor lead before the first burst and lag after the last one.
	task automatic t_monitor();
		int k;
		tx_request <= 1'b1;
		settle(1);
		k = 0;
		while (tx_burst_ok !== 1'b1 && k < 100) begin
			if (pads.out[4] === 1'b1) k++;
			settle(1);
		end
		chk(k, LEAD, "monitor lead");
		@(posedge hclk);
		tx_request <= 1'b0;
		settle(1);
		k = 0;
		while (pads.out[4] === 1'b1 && k < 100) begin
			k++;
			settle(1);
		end
		chk({31'h0, k >= LAG && k <= 2 * LAG}, 32'h1, "monitor lag");
		chk({31'h0, tx_burst_ok}, 32'h0, "activity finished");
	endtask

	// Main sequence; inputs start quiet and reset is held for three cycles.
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ext_lvl = 9'h000;
		ext_en = 9'h000;
		jam = 1'b0;
		tx_request = 1'b0;
		alarm_event = 1'b0;
		buzzer_wave = 1'b0;
		repeat (2) @(posedge hclk);
		t_reset();
		t_input();
		t_output();
		t_alt_sel();
		t_alt_fn();
		t_monitor();
		end_sim();
	end

	// Watchdog: the run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge hclk);
		n_mismatch++;
		end_sim();
	end
endmodule
